//--- msa_host.sv
/*
   msa_host: host side of the main page, issuing byte writes and reads.
   assumes it is driven from the falling edge of ref_clk by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module msa_host
   import msa_pkg::*;
(
   input  wire logic       ref_clk, // system clock
   output var  msa_wr_t    hostWr,  // byte write
   output var  logic [7:0] rdAddr,  // read address
   input  wire logic [7:0] rdData   // read data
);
   initial
   begin
      hostWr = '0;
      rdAddr = 8'h00;
   end

   // strobe stands over the next rising edge and drops at the falling edge after it
   task put(input logic en, input logic [7:0] a, input logic [7:0] d);
      hostWr = '{en, a, d};
      @(negedge ref_clk);
      hostWr.wrEn = 1'h0;
   endtask

   // address set at a falling edge, data taken one cycle later once settled
   task get(input logic [7:0] a, output logic [7:0] q);
      rdAddr = a;
      @(negedge ref_clk);
      q = rdData;
   endtask
endmodule
`default_nettype wire

//--- msa_pkg.sv
/*
   msa_pkg: constants and carrier types for the monitor status and alarm register bank.
   assumes a byte-wide register port on the main page, already decoded from the serial bus.
*/
`default_nettype none
package msa_pkg;
   localparam logic [7:0] MSA_OFS_UPDATE = 8'h6F;
   localparam logic [7:0] MSA_OFS_ALARM0 = 8'h70;
   localparam logic [7:0] MSA_OFS_ALARM1 = 8'h71;
   localparam logic [7:0] MSA_OFS_TSEL   = 8'h7F;
   localparam int MSA_BIT_SUPPLY_UPD = 6;
   localparam int MSA_BIT_AUXA_UPD   = 5;
   localparam int MSA_BIT_AUXB_UPD   = 4;
   localparam int MSA_BIT_SUMMARY    = 0;
   localparam logic [2:0] MSA_UPD_RESET  = 3'h0;
   localparam logic [1:0] MSA_TSEL_RESET = 2'h0;
   localparam int MSA_NCH = 4;

   // one monitored channel: measured value and its two limits
   typedef struct packed {
      logic [15:0] value;
      logic [15:0] limHigh;
      logic [15:0] limLow;
   } msa_chan_t;

   // byte register port
   typedef struct packed {
      logic       wrEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } msa_wr_t;
endpackage
`default_nettype wire

//--- msa_regs.sv
/*
   msa_regs: update flags, alarm flags, masked summary bit and table select of the main page.
   assumes all inputs come from logic on ref_clk; channel order is temperature, supply, aux A, aux B.
*/
`timescale 1ns/1ns
`default_nettype none
module msa_regs
   import msa_pkg::*;
(
   input  wire logic                ref_clk,       // system clock
   input  wire logic                rst_n,         // async reset, active low
   input  wire msa_wr_t             hostWr,        // host byte write
   input  wire logic [7:0]          rdAddr,        // host read address
   output logic [7:0]               rdData,        // read data
   input  wire msa_chan_t [MSA_NCH-1:0] chan,      // measurements and limits
   input  wire logic [2:0]          newResult,     // pulse: supply, aux A, aux B stored [2..0]
   input  wire logic [7:0]          alarmMask,     // mask byte of table one
   output logic [7:0]               alarmFlags_ff, // alarm byte
   output logic                     summaryIntr_ff,// summary interrupt bit
   output logic [1:0]               tableSel_ff    // visible upper table
);
   logic [2:0] updFlags_ff;
   logic [2:0] nxt_updFlags;
   wire  [7:0] nxt_alarmFlags;
   logic       nxt_summary;
   logic [1:0] nxt_tableSel;
   wire        wrUpdate = hostWr.wrEn && (hostWr.addr == MSA_OFS_UPDATE);
   wire        wrTsel   = hostWr.wrEn && (hostWr.addr == MSA_OFS_TSEL);
   wire  [2:0] wrBits   = {hostWr.wdata[MSA_BIT_SUPPLY_UPD], hostWr.wdata[MSA_BIT_AUXA_UPD],
                           hostWr.wdata[MSA_BIT_AUXB_UPD]};

   // set wins over a clearing write in the same cycle
   assign nxt_updFlags = newResult |
                         (wrUpdate ? (updFlags_ff & wrBits) : updFlags_ff);

   // table select keeps its value unless the host writes its byte
   assign nxt_tableSel = wrTsel ? hostWr.wdata[1:0] : tableSel_ff;

   // channel c owns alarm bits 7-2c (high) and 6-2c (low)
   genvar c;
   generate
      for (c = 0; c < MSA_NCH; c++)
      begin : g_cmp
         assign nxt_alarmFlags[7-2*c] =
            chan[c].value > chan[c].limHigh;
         assign nxt_alarmFlags[6-2*c] =
            chan[c].value < chan[c].limLow;
      end
   endgenerate

   assign nxt_summary = |(nxt_alarmFlags & alarmMask);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         updFlags_ff    <= MSA_UPD_RESET;
         tableSel_ff    <= MSA_TSEL_RESET;
         alarmFlags_ff  <= 8'h00;
         summaryIntr_ff <= 1'h0;
      end
      else
      begin
         updFlags_ff    <= nxt_updFlags;
         alarmFlags_ff  <= nxt_alarmFlags;
         summaryIntr_ff <= nxt_summary;
         tableSel_ff    <= nxt_tableSel;
      end
   end

   // unused bits read zero; alarm bytes have no write path
   wire [7:0] rdUpdate = {1'h0, updFlags_ff, 4'h0};
   wire [7:0] rdAlarm1 = {7'h00, summaryIntr_ff};
   wire [7:0] rdTsel   = {6'h00, tableSel_ff};
   assign rdData = (rdAddr == MSA_OFS_UPDATE) ? rdUpdate :
                   (rdAddr == MSA_OFS_ALARM0) ? alarmFlags_ff :
                   (rdAddr == MSA_OFS_ALARM1) ? rdAlarm1 :
                   (rdAddr == MSA_OFS_TSEL)   ? rdTsel : 8'h00;

   property p_updSet;
      @(posedge ref_clk) disable iff (!rst_n) newResult[2] |=> updFlags_ff[2];
   endproperty
   a_updSet: assert property (p_updSet)
      else $error("supply update flag not set");

   property p_auxAClr;
      @(posedge ref_clk) disable iff (!rst_n)
         wrUpdate && !hostWr.wdata[MSA_BIT_AUXA_UPD] && !newResult[1] |=> !updFlags_ff[1];
   endproperty
   a_auxAClr: assert property (p_auxAClr)
      else $error("aux A flag not cleared");

   property p_auxBHold;
      @(posedge ref_clk) disable iff (!rst_n)
         !updFlags_ff[0] && !newResult[0] |=> !updFlags_ff[0];
   endproperty
   a_auxBHold: assert property (p_auxBHold)
      else $error("aux B flag rose without update");

   property p_tempHigh;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[0].value > chan[0].limHigh) |=> alarmFlags_ff[7];
   endproperty
   a_tempHigh: assert property (p_tempHigh)
      else $error("temperature high alarm missed");

   property p_supplyLow;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[1].value >= chan[1].limLow) |=> !alarmFlags_ff[4];
   endproperty
   a_supplyLow: assert property (p_supplyLow)
      else $error("false supply low alarm");

   property p_auxAHigh;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[2].value > chan[2].limHigh) |=> alarmFlags_ff[3];
   endproperty
   a_auxAHigh: assert property (p_auxAHigh)
      else $error("aux A high alarm missed");

   property p_auxBLow;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[3].value < chan[3].limLow) |=> alarmFlags_ff[0];
   endproperty
   a_auxBLow: assert property (p_auxBLow)
      else $error("aux B low alarm missed");

   property p_maskZero;
      @(posedge ref_clk) disable iff (!rst_n) (alarmMask == 8'h00) |=> !summaryIntr_ff;
   endproperty
   a_maskZero: assert property (p_maskZero)
      else $error("summary set under zero mask");

   property p_summary;
      @(posedge ref_clk) disable iff (!rst_n)
         ##1 summaryIntr_ff == |(alarmFlags_ff & $past(alarmMask));
   endproperty
   a_summary: assert property (p_summary)
      else $error("summary bit mismatch");

   property p_tsel;
      @(posedge ref_clk) disable iff (!rst_n) wrTsel |=> tableSel_ff == $past(hostWr.wdata[1:0]);
   endproperty
   a_tsel: assert property (p_tsel)
      else $error("table select not written");

   property p_unused;
      @(posedge ref_clk) disable iff (!rst_n)
         (rdAddr == MSA_OFS_TSEL) |-> rdData[7:2] == 6'h00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused bits read nonzero");

   property p_limits;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[3].value <= chan[3].limHigh) |=> !alarmFlags_ff[1];
   endproperty
   a_limits: assert property (p_limits)
      else $error("false aux B high alarm");

   property p_tempLow;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[0].value < chan[0].limLow) |=> alarmFlags_ff[6];
   endproperty
   a_tempLow: assert property (p_tempLow)
      else $error("temperature low alarm missed");

   property p_supplyHigh;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[1].value > chan[1].limHigh) |=> alarmFlags_ff[5];
   endproperty
   a_supplyHigh: assert property (p_supplyHigh)
      else $error("supply high alarm missed");

   property p_auxALow;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[2].value < chan[2].limLow) |=> alarmFlags_ff[2];
   endproperty
   a_auxALow: assert property (p_auxALow)
      else $error("aux A low alarm missed");

   property p_auxBHigh;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[3].value > chan[3].limHigh) |=> alarmFlags_ff[1];
   endproperty
   a_auxBHigh: assert property (p_auxBHigh)
      else $error("aux B high alarm missed");

   property p_auxASet;
      @(posedge ref_clk) disable iff (!rst_n) newResult[1] |=> updFlags_ff[1];
   endproperty
   a_auxASet: assert property (p_auxASet)
      else $error("aux A update flag not set");

   property p_auxBSet;
      @(posedge ref_clk) disable iff (!rst_n) newResult[0] |=> updFlags_ff[0];
   endproperty
   a_auxBSet: assert property (p_auxBSet)
      else $error("aux B update flag not set");

   property p_supplyClr;
      @(posedge ref_clk) disable iff (!rst_n)
         wrUpdate && !hostWr.wdata[MSA_BIT_SUPPLY_UPD] && !newResult[2] |=> !updFlags_ff[2];
   endproperty
   a_supplyClr: assert property (p_supplyClr)
      else $error("supply flag not cleared");

   property p_supplyHold;
      @(posedge ref_clk) disable iff (!rst_n)
         !updFlags_ff[2] && !newResult[2] |=> !updFlags_ff[2];
   endproperty
   a_supplyHold: assert property (p_supplyHold)
      else $error("supply flag rose without update");

   property p_tselHold;
      @(posedge ref_clk) disable iff (!rst_n) !wrTsel |=> $stable(tableSel_ff);
   endproperty
   a_tselHold: assert property (p_tselHold)
      else $error("table select changed without its write");

   property p_updUnused;
      @(posedge ref_clk) disable iff (!rst_n)
         (rdAddr == MSA_OFS_UPDATE) |-> (rdData[7] == 1'h0) && (rdData[3:0] == 4'h0);
   endproperty
   a_updUnused: assert property (p_updUnused)
      else $error("unused update bits read nonzero");

   property p_alarm1Unused;
      @(posedge ref_clk) disable iff (!rst_n)
         (rdAddr == MSA_OFS_ALARM1) |-> rdData[7:1] == 7'h00;
   endproperty
   a_alarm1Unused: assert property (p_alarm1Unused)
      else $error("unused summary byte bits read nonzero");

   property p_summaryOne;
      @(posedge ref_clk) disable iff (!rst_n)
         (chan[0].value > chan[0].limHigh) && alarmMask[7] |=> summaryIntr_ff;
   endproperty
   a_summaryOne: assert property (p_summaryOne)
      else $error("summary bit missed an unmasked alarm");
endmodule
`default_nettype wire

//--- tb_monitor_status_alarm_regs.sv
/*
   tb_monitor_status_alarm_regs: random writes, results and limits against a bench model.
   assumes msa_regs and msa_host are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_monitor_status_alarm_regs
   import msa_pkg::*;
;
   logic ref_clk = 1'h0, rst_n = 1'h0, en, summaryIntr_ff;
   msa_wr_t hostWr;
   msa_chan_t [MSA_NCH-1:0] chan = '0;
   logic [7:0] rdAddr, rdData, alarmFlags_ff, alM, a, d, alarmMask = 8'h00;
   logic [2:0] newResult = 3'h0, updM = 3'h0;
   logic [1:0] tableSel_ff, tselM = 2'h0;
   logic [7:0] adr [6] = '{MSA_OFS_UPDATE, MSA_OFS_TSEL, MSA_OFS_ALARM0, MSA_OFS_ALARM1, 8'h72,
                          MSA_OFS_UPDATE};
   int n_mismatch = 0, n_compared = 0, seed = 63;
   msa_host u_host (.ref_clk(ref_clk), .hostWr(hostWr), .rdAddr(rdAddr), .rdData(rdData));
   msa_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hostWr(hostWr), .rdAddr(rdAddr),
      .rdData(rdData), .chan(chan), .newResult(newResult), .alarmMask(alarmMask),
      .alarmFlags_ff(alarmFlags_ff), .summaryIntr_ff(summaryIntr_ff), .tableSel_ff(tableSel_ff));
   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end
   function logic [15:0] r4();
      return 16'({$random(seed)} % 4);
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task give_verdict();
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(negedge ref_clk);
      rst_n = 1'h1;
      for (int it = 0; it < 400; it++)
      begin
         if (it == 200)
         begin
            // reset in mid-run: every register falls back to its reset value
            rst_n = 1'h0;
            @(negedge ref_clk);
            chk(alarmFlags_ff, 8'h00);
            chk({7'h00, summaryIntr_ff}, 8'h00);
            chk({6'h00, tableSel_ff}, {6'h00, MSA_TSEL_RESET});
            u_host.get(MSA_OFS_UPDATE, d);
            chk(d, {1'h0, MSA_UPD_RESET, 4'h0});
            rst_n = 1'h1;
            updM = MSA_UPD_RESET;
            tselM = MSA_TSEL_RESET;
         end
         for (int i = 0; i < MSA_NCH; i++)
         begin
            chan[i] = {r4(), r4(), r4()};
            alM[7-2*i] = chan[i].value > chan[i].limHigh;
            alM[6-2*i] = chan[i].value < chan[i].limLow;
         end
         // every eighth pass forces an all-zero mask
         alarmMask = (it % 8 == 0) ? 8'h00 : 8'($random(seed));
         newResult = 3'($random(seed));
         en = 1'($random(seed));
         a = adr[{$random(seed)} % 6];
         d = 8'($random(seed));
         // set beats clear, written ones do not set
         if (en && a == MSA_OFS_UPDATE)
            updM = updM & {d[MSA_BIT_SUPPLY_UPD], d[MSA_BIT_AUXA_UPD], d[MSA_BIT_AUXB_UPD]};
         updM = updM | newResult;
         if (en && a == MSA_OFS_TSEL)
            tselM = d[1:0];
         u_host.put(en, a, d);
         newResult = 3'h0;
         @(negedge ref_clk);
         chk(alarmFlags_ff, alM);
         chk({7'h00, summaryIntr_ff}, {7'h00, |(alM & alarmMask)});
         chk({6'h00, tableSel_ff}, {6'h00, tselM});
         u_host.get(MSA_OFS_UPDATE, d);
         chk(d, {1'h0, updM, 4'h0});
         u_host.get(MSA_OFS_ALARM0, d);
         chk(d, alM);
         u_host.get(MSA_OFS_ALARM1, d);
         chk(d, {7'h00, |(alM & alarmMask)});
         u_host.get(MSA_OFS_TSEL, d);
         chk(d, {6'h00, tselM});
         u_host.get(8'h72, d);
         chk(d, 8'h00);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
